// ==== pkg/wdg_pkg.sv ====
// package: register map, field layout, timing constants and carriers
package wdg_pkg;
    localparam logic [14:0] ADDR_FLAGS = 15'h7ff0;
    localparam logic [14:0] ADDR_IRQEN = 15'h7ff6;
    localparam logic [14:0] ADDR_TCTL = 15'h7ff7;
    localparam int ADDR_W = 15;
    // field positions
    localparam int TCTL_STEER = 7;
    localparam int TCTL_MULT_HI = 6;
    localparam int TCTL_MULT_LO = 2;
    localparam int FLAG_TIMEOUT = 7;
    localparam int FLAG_ALARM = 6;
    localparam int FLAG_BATLOW = 4;
    localparam int IRQEN_ALARM = 7;
    localparam int IRQEN_BACKUP = 5;
    localparam logic [7:0] IRQEN_MASK = 8'ha0;
    localparam logic [7:0] TCTL_RESET = 8'h00;
    // resolution codes
    localparam logic [1:0] RES_16TH = 2'h0;
    localparam logic [1:0] RES_QUARTER = 2'h1;
    localparam logic [1:0] RES_ONE = 2'h2;
    localparam logic [1:0] RES_FOUR = 2'h3;
    // resolution units in 1/16 s ticks
    localparam logic [6:0] UNIT_16TH = 7'h01;
    localparam logic [6:0] UNIT_QUARTER = 7'h04;
    localparam logic [6:0] UNIT_ONE = 7'h10;
    localparam logic [6:0] UNIT_FOUR = 7'h40;
    // timing
    localparam int CLK_HZ = 50000000;
    localparam int OSC_HZ = 32768;
    localparam int TICK_HZ = 16;
    localparam int ADDR_STABLE_NS = 15;
    localparam int CLK_NS = 20;
    localparam int STABLE_CYC_I = (ADDR_STABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] STABLE_CYC = 2'(STABLE_CYC_I < 1 ? 1 :
        STABLE_CYC_I);
    localparam int RECOVERY_MS = 40;
    localparam int RECOVERY_TICKS_I = (RECOVERY_MS * TICK_HZ + 999) / 1000;
    localparam logic [7:0] RECOVERY_TICKS = 8'(RECOVERY_TICKS_I);
    localparam int FT_HZ = 512;
    localparam logic [7:0] FT_HALF_DIV = 8'(OSC_HZ / (2 * FT_HZ));
    localparam logic [11:0] TICK_DIV = 12'(OSC_HZ / TICK_HZ);

    // host bus carrier
    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] wdata;
        logic chipEn;
        logic rdEn;
        logic wrEn;
    } wdg_bus_t;

    // oscillator prescaler state
    typedef struct packed {
        logic [11:0] tickDiv;
        logic [7:0] ftDiv;
        logic ftWave;
        logic tick;
        logic ftEdge;
    } wdg_pre_t;
endpackage : wdg_pkg

// ==== hdl/wdg_prescaler.sv ====
// module: oscillator prescaler giving watchdog ticks and test wave
`timescale 1ns/1ps
module wdg_prescaler (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // oscillator enable pulse at 32768 Hz
    input wire logic oscEn,
    // outputs
    output logic tick,
    output logic ftWave
);
    wdg_pkg::wdg_pre_t st_r;
    wdg_pkg::wdg_pre_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.ftEdge = 1'b0;
        if (oscEn) begin
            if (st_r.tickDiv == wdg_pkg::TICK_DIV - 12'h001) begin
                st_nxt.tickDiv = 12'h000;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.tickDiv = st_r.tickDiv + 12'h001;
            end
            if (st_r.ftDiv == wdg_pkg::FT_HALF_DIV - 8'h01) begin
                st_nxt.ftDiv = 8'h00;
                st_nxt.ftWave = ~st_r.ftWave;
                st_nxt.ftEdge = 1'b1;
            end else begin
                st_nxt.ftDiv = st_r.ftDiv + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
    assign ftWave = st_r.ftWave;
endmodule : wdg_prescaler

// ==== hdl/wdg_irq_flag_logic.sv ====
// module: watchdog, interrupt steering, flags and power-fail reset
`timescale 1ns/1ps
// What this block does
// - timeout equals five-bit multiplier times selected resolution unit
// - low two bits pick 1/16 s, 1/4 s, 1 s or 4 s unit
// - missed restart sets timeout flag and raises interrupt or reset
// - reading the flags register clears the timeout flag
// - read clear only after address stable on flags for 15 ns
// - steering 0 drives interrupt output, 1 pulses reset output
// - reset-steered expiry clears timeout control, test and alarm enables
// - rewrite of timeout control or kick edge restarts the count
// - timeout control of all zeros disables the watchdog
// - interrupt from timeout holds until host writes zero to control
// - power-down disables watchdog and clears timeout control
// - interrupts override the frequency test wave on the shared output
// - power fail holds reset low, then for recovery time after return
// - alarm or timeout sets its flag regardless of output enables
// - alarm enables and steering bit gate events onto the output
// - qualified flags read clears alarm flag and releases output
// - shared output released unless interrupt pending or test active
// - battery low flag set by failed power-up check, kept until pass
// - battery checks happen only with main supply present
// - power-up clears hold bits, test, alarm enables, timeout control
// - during power-down alarm enables keep value, others read zero
module wdg_irq_flag_logic #(
    parameter logic [7:0] RECOVERY_TICKS = wdg_pkg::RECOVERY_TICKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // oscillator enable pulse at 32768 Hz
    input wire logic oscEn,
    // host parallel bus
    input wire logic [14:0] hostAddr,
    input wire logic [7:0] hostWdata,
    input wire logic hostChipEnN,
    input wire logic hostRdEnN,
    input wire logic hostWrEnN,
    output logic [7:0] hostRdata,
    output logic hostRdataOe,
    // clock core hooks
    input wire logic alarmMatch,
    input wire logic clockStopped,
    input wire logic hostWrHoldIn,
    input wire logic hostRdHoldIn,
    input wire logic freqTestIn,
    output logic freqTestEnable,
    output logic clockWriteHold,
    output logic clockReadHold,
    // supply supervision
    input wire logic power_fail_trip,
    input wire logic batteryCheckLow,
    input wire logic batteryCheckDone,
    // kick input pin
    input wire logic kick_input,
    // open drain outputs
    output logic irq_or_test_out_n,
    output logic irqOrTestOe,
    output logic resetOutN,
    output logic resetOutOe
);
    typedef enum logic [1:0] {PWR_UP, PWR_DOWN, PWR_RECOVER} wdg_pwr_t;

    typedef struct packed {
        logic [2:0] kickSync;
        logic kickLast;
        logic [2:0] pfSync;
        wdg_pwr_t pwr;
        logic [7:0] recCnt;
        logic wdgPulse;
        logic [7:0] timeout_control;
        logic alarm_irq_enable;
        logic alarm_backup_enable;
        logic freq_test_enable;
        logic wrHold;
        logic rdHold;
        logic timeout_flag;
        logic alarm_flag;
        logic battery_low_flag;
        logic wdgIrq;
        logic [11:0] wdgCnt;
        logic [1:0] stableCnt;
        logic rdCleared;
        logic [7:0] rdata;
        logic rdataOe;
        logic irqN;
        logic irqOe;
        logic rstN;
        logic rstOe;
    } wdg_state_t;

    wdg_state_t st_r;
    wdg_state_t st_nxt;
    logic tick;
    logic ftWave;
    logic [7:0] flagsView;
    logic [7:0] irqenView;
    logic [7:0] tctlView;
    logic [11:0] fullCount;
    logic [6:0] unitTicks;

    wdg_prescaler u_pre (
        .core_clk(core_clk),
        .resetn(resetn),
        .oscEn(oscEn),
        .tick(tick),
        .ftWave(ftWave)
    );

    // resolution unit and full timeout in 1/16 s ticks
    always_comb begin
        case (st_r.timeout_control[1:0])
            wdg_pkg::RES_16TH: unitTicks = wdg_pkg::UNIT_16TH;
            wdg_pkg::RES_QUARTER: unitTicks = wdg_pkg::UNIT_QUARTER;
            wdg_pkg::RES_ONE: unitTicks = wdg_pkg::UNIT_ONE;
            wdg_pkg::RES_FOUR: unitTicks = wdg_pkg::UNIT_FOUR;
            default: unitTicks = wdg_pkg::UNIT_16TH;
        endcase
    end
    assign fullCount = 12'(st_r.timeout_control[wdg_pkg::TCTL_MULT_HI:
        wdg_pkg::TCTL_MULT_LO]) * 12'(unitTicks);

    // register read views; hold and test bits have no read view
    always_comb begin
        flagsView = 8'h00;
        flagsView[wdg_pkg::FLAG_TIMEOUT] = st_r.timeout_flag;
        flagsView[wdg_pkg::FLAG_ALARM] = st_r.alarm_flag;
        flagsView[wdg_pkg::FLAG_BATLOW] = st_r.battery_low_flag;
        irqenView = 8'h00;
        irqenView[wdg_pkg::IRQEN_ALARM] = st_r.alarm_irq_enable;
        irqenView[wdg_pkg::IRQEN_BACKUP] = st_r.alarm_backup_enable;
        tctlView = st_r.timeout_control;
    end

    always_comb begin
        logic rdActive;
        logic onFlags;
        logic wrStrobe;
        logic kickEdge;
        logic pfNow;
        logic expire;
        logic down;
        logic alarmIrq;
        logic ftActive;
        rdActive = 1'b0;
        onFlags = 1'b0;
        wrStrobe = 1'b0;
        kickEdge = 1'b0;
        pfNow = 1'b0;
        expire = 1'b0;
        down = 1'b0;
        alarmIrq = 1'b0;
        ftActive = 1'b0;
        st_nxt = st_r;

        // three-stage pin synchronisers
        st_nxt.kickSync = {st_r.kickSync[1:0], kick_input};
        st_nxt.pfSync = {st_r.pfSync[1:0], power_fail_trip};
        if (st_r.kickSync[2] == st_r.kickSync[1]) begin
            st_nxt.kickLast = st_r.kickSync[2];
        end
        kickEdge = (st_r.kickSync[2] == st_r.kickSync[1]) &&
            (st_r.kickSync[2] != st_r.kickLast);
        pfNow = st_r.pfSync[2];
        if (st_r.pfSync[2] != st_r.pfSync[1]) begin
            pfNow = (st_r.pwr == PWR_DOWN);
        end

        // power sequencing
        case (st_r.pwr)
            PWR_UP: begin
                if (pfNow) begin
                    st_nxt.pwr = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (!pfNow) begin
                    st_nxt.pwr = PWR_RECOVER;
                    st_nxt.recCnt = RECOVERY_TICKS;
                end
            end
            PWR_RECOVER: begin
                if (pfNow) begin
                    st_nxt.pwr = PWR_DOWN;
                end else if (tick) begin
                    if (st_r.recCnt <= 8'h01) begin
                        st_nxt.pwr = PWR_UP;
                    end else begin
                        st_nxt.recCnt = st_r.recCnt - 8'h01;
                    end
                end
            end
            default: st_nxt.pwr = PWR_DOWN;
        endcase
        down = (st_nxt.pwr != PWR_UP);

        // host bus decode; writes ignored while down
        rdActive = !hostChipEnN && !hostRdEnN && hostWrEnN;
        wrStrobe = !hostChipEnN && !hostWrEnN && !down;
        onFlags = rdActive && (hostAddr == wdg_pkg::ADDR_FLAGS);
        st_nxt.rdataOe = rdActive;
        case (hostAddr)
            wdg_pkg::ADDR_FLAGS: st_nxt.rdata = flagsView;
            wdg_pkg::ADDR_IRQEN: st_nxt.rdata = irqenView;
            wdg_pkg::ADDR_TCTL: st_nxt.rdata = tctlView;
            default: st_nxt.rdata = 8'h00;
        endcase
        // flags data latched on the first read cycle, held while the flags read lasts
        if (onFlags && st_r.stableCnt != 2'h0) begin
            st_nxt.rdata = st_r.rdata;
        end

        // qualified flags read: address stable long enough
        if (!onFlags) begin
            st_nxt.stableCnt = 2'h0;
            st_nxt.rdCleared = 1'b0;
        end else if (st_r.stableCnt < wdg_pkg::STABLE_CYC) begin
            st_nxt.stableCnt = st_r.stableCnt + 2'h1;
        end
        if (onFlags && !st_r.rdCleared &&
            st_r.stableCnt >= wdg_pkg::STABLE_CYC) begin
            st_nxt.rdCleared = 1'b1;
            st_nxt.timeout_flag = 1'b0;
            st_nxt.alarm_flag = 1'b0;
        end

        // register writes
        if (wrStrobe && hostAddr == wdg_pkg::ADDR_TCTL) begin
            st_nxt.timeout_control = hostWdata;
            st_nxt.wdgCnt = 12'h000;
            if (hostWdata == wdg_pkg::TCTL_RESET) begin
                st_nxt.wdgIrq = 1'b0;
            end
        end
        if (wrStrobe && hostAddr == wdg_pkg::ADDR_IRQEN) begin
            st_nxt.alarm_irq_enable = hostWdata[wdg_pkg::IRQEN_ALARM];
            st_nxt.alarm_backup_enable = hostWdata[wdg_pkg::IRQEN_BACKUP];
        end
        st_nxt.freq_test_enable = freqTestIn;
        st_nxt.wrHold = hostWrHoldIn;
        st_nxt.rdHold = hostRdHoldIn;

        // watchdog count
        if (kickEdge) begin
            st_nxt.wdgCnt = 12'h000;
        end else if (tick && st_r.timeout_control != wdg_pkg::TCTL_RESET
            && !down) begin
            if (st_r.wdgCnt + 12'h001 >= fullCount) begin
                expire = 1'b1;
                st_nxt.wdgCnt = 12'h000;
            end else begin
                st_nxt.wdgCnt = st_r.wdgCnt + 12'h001;
            end
        end
        st_nxt.wdgPulse = 1'b0;
        if (expire) begin
            if (st_r.timeout_control[wdg_pkg::TCTL_STEER]) begin
                st_nxt.wdgPulse = 1'b1;
                st_nxt.pwr = PWR_RECOVER;
                st_nxt.recCnt = RECOVERY_TICKS;
                st_nxt.timeout_control = wdg_pkg::TCTL_RESET;
                st_nxt.alarm_irq_enable = 1'b0;
                st_nxt.alarm_backup_enable = 1'b0;
                st_nxt.freq_test_enable = 1'b0;
            end else begin
                st_nxt.wdgIrq = 1'b1;
            end
        end

        // flags: set wins over read clear
        if (expire) begin
            st_nxt.timeout_flag = 1'b1;
        end
        if (alarmMatch) begin
            st_nxt.alarm_flag = 1'b1;
        end
        if (st_r.pwr == PWR_RECOVER && batteryCheckDone &&
            !pfNow) begin
            st_nxt.battery_low_flag = batteryCheckLow;
        end

        // power-down and power-up defaults
        if (st_nxt.pwr == PWR_DOWN) begin
            st_nxt.timeout_control = wdg_pkg::TCTL_RESET;
            st_nxt.wdgCnt = 12'h000;
            st_nxt.wdgIrq = 1'b0;
            st_nxt.freq_test_enable = 1'b0;
            st_nxt.wrHold = 1'b0;
            st_nxt.rdHold = 1'b0;
        end
        if (st_r.pwr == PWR_DOWN && st_nxt.pwr == PWR_RECOVER) begin
            st_nxt.alarm_irq_enable = 1'b0;
            st_nxt.alarm_backup_enable = 1'b0;
            st_nxt.timeout_control = wdg_pkg::TCTL_RESET;
        end
        if (down) begin
            st_nxt.freq_test_enable = 1'b0;
            st_nxt.wrHold = 1'b0;
            st_nxt.rdHold = 1'b0;
        end

        // shared interrupt / test output
        alarmIrq = st_r.alarm_flag && st_r.alarm_irq_enable &&
            (!down || st_r.alarm_backup_enable);
        ftActive = st_r.freq_test_enable && !clockStopped &&
            !st_r.alarm_irq_enable &&
            (st_r.timeout_control[wdg_pkg::TCTL_STEER] ||
             st_r.timeout_control == wdg_pkg::TCTL_RESET);
        if (st_r.wdgIrq || alarmIrq) begin
            st_nxt.irqN = 1'b0;
            st_nxt.irqOe = 1'b1;
        end else if (ftActive) begin
            st_nxt.irqN = ftWave;
            st_nxt.irqOe = !ftWave;
        end else begin
            st_nxt.irqN = 1'b1;
            st_nxt.irqOe = 1'b0;
        end

        // reset output: low while down or recovering
        st_nxt.rstN = !(down || st_nxt.wdgPulse);
        st_nxt.rstOe = down || st_nxt.wdgPulse;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.pwr <= PWR_RECOVER;
            st_r.recCnt <= RECOVERY_TICKS;
            st_r.irqN <= 1'b1;
            st_r.rstN <= 1'b0;
            st_r.rstOe <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hostRdata = st_r.rdata;
    assign hostRdataOe = st_r.rdataOe;
    assign freqTestEnable = st_r.freq_test_enable;
    assign clockWriteHold = st_r.wrHold;
    assign clockReadHold = st_r.rdHold;
    assign irq_or_test_out_n = st_r.irqN;
    assign irqOrTestOe = st_r.irqOe;
    assign resetOutN = st_r.rstN;
    assign resetOutOe = st_r.rstOe;
endmodule : wdg_irq_flag_logic

// ==== dv/wdg_irq_flag_logic_assertions.sv ====
// checker: concurrent assertions on the watchdog block ports
`timescale 1ns/1ps
module wdg_irq_flag_logic_assertions #(
    parameter logic [7:0] RECOVERY_TICKS = wdg_pkg::RECOVERY_TICKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // inputs watched
    input wire logic oscEn,
    input wire logic [14:0] hostAddr,
    input wire logic hostChipEnN,
    input wire logic hostRdEnN,
    input wire logic power_fail_trip,
    // outputs watched
    input wire logic [7:0] hostRdata,
    input wire logic freqTestEnable,
    input wire logic clockWriteHold,
    input wire logic clockReadHold,
    input wire logic irq_or_test_out_n,
    input wire logic irqOrTestOe,
    input wire logic resetOutN,
    input wire logic resetOutOe
);
    localparam int PULSE_MAX = (int'(RECOVERY_TICKS) + 1) * 2048 + 16;
    logic rdAct;
    logic pwrRecov_r;
    logic [19:0] lowCnt_r;
    assign rdAct = !hostChipEnN && !hostRdEnN;
    // oscillator pulses while reset output is low after supply return
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lowCnt_r <= '0;
            pwrRecov_r <= 1'b1;
        end else begin
            pwrRecov_r <= power_fail_trip || (pwrRecov_r && !resetOutN);
            if (resetOutN || power_fail_trip) begin
                lowCnt_r <= '0;
            end else if (oscEn && lowCnt_r != '1) begin
                lowCnt_r <= lowCnt_r + 20'h00001;
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    pfail_reset_low_a: assert property (
        $rose(power_fail_trip) |-> ##[1:6] !resetOutN)
        else $error("reset output not low after power fail");
    reset_pulse_len_a: assert property (
        !resetOutN |-> lowCnt_r <= 20'(PULSE_MAX))
        else $error("reset output held low too long");
    reset_open_drain_a: assert property (
        resetOutOe == !resetOutN)
        else $error("reset output enable does not match level");
    irq_open_drain_a: assert property (
        irqOrTestOe == !irq_or_test_out_n)
        else $error("irq output enable does not match level");
    irq_holds_a: assert property (
        !irq_or_test_out_n && !freqTestEnable && !$past(freqTestEnable)
        && resetOutN && hostChipEnN && $past(hostChipEnN)
        && $past(hostChipEnN, 2) |=> !irq_or_test_out_n)
        else $error("irq output released without host action");
    pdown_controls_a: assert property (
        power_fail_trip [*5] |->
        !freqTestEnable && !clockWriteHold && !clockReadHold)
        else $error("control bits not zero during power down");
    recov_controls_a: assert property (
        (pwrRecov_r && !resetOutN) [*3] |->
        !freqTestEnable && !clockWriteHold && !clockReadHold)
        else $error("control bits not zero during power up");
    flags_frozen_a: assert property (
        (rdAct && hostAddr == wdg_pkg::ADDR_FLAGS) [*3] |->
        $stable(hostRdata))
        else $error("flags read data changed within one read");
endmodule : wdg_irq_flag_logic_assertions

bind wdg_irq_flag_logic wdg_irq_flag_logic_assertions #(
    .RECOVERY_TICKS(RECOVERY_TICKS)
) i_wdg_chk (
    .core_clk(core_clk), .resetn(resetn), .oscEn(oscEn),
    .hostAddr(hostAddr), .hostChipEnN(hostChipEnN), .hostRdEnN(hostRdEnN),
    .power_fail_trip(power_fail_trip), .hostRdata(hostRdata),
    .freqTestEnable(freqTestEnable), .clockWriteHold(clockWriteHold),
    .clockReadHold(clockReadHold), .irq_or_test_out_n(irq_or_test_out_n),
    .irqOrTestOe(irqOrTestOe), .resetOutN(resetOutN),
    .resetOutOe(resetOutOe)
);

// ==== dv/wdg_host_model.sv ====
// host microprocessor model driving the parallel bus
`timescale 1ns/1ps
module wdg_host_model (
    // clock
    input wire logic core_clk,
    // bus towards the device, enables active high
    output wdg_pkg::wdg_bus_t hostBus
);
    initial begin
        hostBus = '0;
    end
    // released enables go low, address and data lines show the inverse of their last value
    task automatic bus_release();
        @(negedge core_clk);
        hostBus.chipEn = 1'b0;
        hostBus.rdEn = 1'b0;
        hostBus.wrEn = 1'b0;
        hostBus.addr = ~hostBus.addr;
        hostBus.wdata = ~hostBus.wdata;
    endtask : bus_release
    // one write, taken at the next rising edge
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(negedge core_clk);
        hostBus.addr = a;
        hostBus.wdata = d;
        hostBus.chipEn = 1'b1;
        hostBus.wrEn = 1'b1;
        bus_release();
    endtask : wr
    // one read, address held over five rising edges
    task automatic rd(input logic [14:0] a);
        @(negedge core_clk);
        hostBus.addr = a;
        hostBus.chipEn = 1'b1;
        hostBus.rdEn = 1'b1;
        repeat (4) @(negedge core_clk);
        bus_release();
    endtask : rd
endmodule : wdg_host_model

// ==== dv/wdg_irq_flag_logic_test.sv ====
// self-checking bench for the watchdog, interrupt and flag block
`timescale 1ns/1ps
module wdg_irq_flag_logic_test;
    logic core_clk, resetn, oscEn, alarmMatch, clockStopped;
    logic hostWrHoldIn, hostRdHoldIn, freqTestIn, power_fail_trip;
    logic batteryCheckLow, batteryCheckDone, kick_input, oePrev;
    logic [7:0] hostRdata;
    logic hostRdataOe, freqTestEnable, clockWriteHold, clockReadHold;
    logic irq_or_test_out_n, irqOrTestOe, resetOutN, resetOutOe;
    wdg_pkg::wdg_bus_t hostBus;
    logic [7:0] expQ[$];
    logic [31:0] seed;
    int error_cnt = 0;
    int num_checks = 0;

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    wdg_host_model i_host (.core_clk(core_clk), .hostBus(hostBus));

    wdg_irq_flag_logic #(.RECOVERY_TICKS(8'h01)) i_dut (
        .core_clk(core_clk), .resetn(resetn), .oscEn(oscEn),
        .hostAddr(hostBus.addr), .hostWdata(hostBus.wdata),
        .hostChipEnN(!hostBus.chipEn), .hostRdEnN(!hostBus.rdEn),
        .hostWrEnN(!hostBus.wrEn), .hostRdata(hostRdata),
        .hostRdataOe(hostRdataOe), .alarmMatch(alarmMatch),
        .clockStopped(clockStopped), .hostWrHoldIn(hostWrHoldIn),
        .hostRdHoldIn(hostRdHoldIn), .freqTestIn(freqTestIn),
        .freqTestEnable(freqTestEnable), .clockWriteHold(clockWriteHold),
        .clockReadHold(clockReadHold), .power_fail_trip(power_fail_trip),
        .batteryCheckLow(batteryCheckLow),
        .batteryCheckDone(batteryCheckDone), .kick_input(kick_input),
        .irq_or_test_out_n(irq_or_test_out_n), .irqOrTestOe(irqOrTestOe),
        .resetOutN(resetOutN), .resetOutOe(resetOutOe)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic pin(input bit selRst);
        return selRst ? resetOutN : irq_or_test_out_n;
    endfunction : pin
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rd_exp(input logic [14:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_host.rd(a);
    endtask : rd_exp
    task automatic wait_pin(input bit selRst, input logic lvl, input int mx);
        int n;
        n = 0;
        while (pin(selRst) !== lvl && n < mx) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h00, pin(selRst)}, {7'h00, lvl}, "pin level");
    endtask : wait_pin
    task automatic count_hi(input int cyc, output int hi);
        hi = 0;
        repeat (cyc) begin
            @(negedge core_clk);
            if (irq_or_test_out_n === 1'b1) hi++;
        end
    endtask : count_hi
    task automatic pulse_alarm();
        @(negedge core_clk);
        alarmMatch = 1'b1;
        @(negedge core_clk);
        alarmMatch = 1'b0;
    endtask : pulse_alarm
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // read results compared against the oldest note
    always @(negedge core_clk) begin
        if (hostRdataOe === 1'b1 && oePrev !== 1'b1) begin
            if (expQ.size() == 0) begin
                error_cnt++;
                $display("[FAIL] %0t read data with no note", $time);
            end else begin
                chk(hostRdata, expQ.pop_front(), "read data");
            end
        end
        oePrev <= hostRdataOe;
    end

    initial begin
        #(20 * 80000);
        error_cnt++;
        $display("[FAIL] %0t run did not finish", $time);
        end_of_test();
    end

    initial begin
        int n;
        int hi;
        logic [7:0] irqDat;
        {resetn, alarmMatch, clockStopped, freqTestIn} = 4'h0;
        {power_fail_trip, batteryCheckLow, batteryCheckDone} = 3'h0;
        {oscEn, hostWrHoldIn, hostRdHoldIn, kick_input} = 4'he;
        seed = 32'h6cbad151;
        repeat (10) @(negedge core_clk);
        resetn = 1'b1;
        wait_pin(1, 1'b1, 5000);
        rd_exp(wdg_pkg::ADDR_TCTL, 8'h00);
        rd_exp(wdg_pkg::ADDR_IRQEN, 8'h00);
        rd_exp(15'h0123, 8'h00);
        $display("test defaults done");
        i_host.wr(wdg_pkg::ADDR_TCTL, 8'h05);
        rd_exp(wdg_pkg::ADDR_TCTL, 8'h05);
        repeat (5000) @(negedge core_clk);
        chk({7'h00, irq_or_test_out_n}, 8'h01, "early expiry");
        wait_pin(0, 1'b0, 6000);
        freqTestIn = 1'b1;
        count_hi(100, hi);
        chk(8'(hi), 8'h00, "test wave over irq");
        rd_exp(wdg_pkg::ADDR_FLAGS, 8'h80);
        rd_exp(wdg_pkg::ADDR_FLAGS, 8'h00);
        chk({7'h00, irq_or_test_out_n}, 8'h00, "irq held");
        i_host.wr(wdg_pkg::ADDR_TCTL, 8'h00);
        count_hi(200, hi);
        chk({7'h00, hi > 0 && hi < 200}, 8'h01, "test wave");
        freqTestIn = 1'b0;
        repeat (5) @(negedge core_clk);
        count_hi(5000, hi);
        chk({7'h00, hi == 5000}, 8'h01, "disabled watchdog");
        $display("test irq steering done");
        i_host.wr(wdg_pkg::ADDR_TCTL, 8'h0c);
        for (n = 0; n < 6; n++) begin
            seed = lfsr(seed);
            repeat (1200 + int'(seed[8:0])) @(negedge core_clk);
            if (n == 3) i_host.wr(wdg_pkg::ADDR_TCTL, 8'h0c);
            else kick_input = ~kick_input;
        end
        chk({7'h00, irq_or_test_out_n}, 8'h01, "kick restart");
        wait_pin(0, 1'b0, 9000);
        rd_exp(wdg_pkg::ADDR_FLAGS, 8'h80);
        i_host.wr(wdg_pkg::ADDR_TCTL, 8'h00);
        wait_pin(0, 1'b1, 5);
        $display("test kick done");
        seed = lfsr(seed);
        irqDat = seed[7:0] | 8'h80;
        i_host.wr(wdg_pkg::ADDR_IRQEN, irqDat);
        rd_exp(wdg_pkg::ADDR_IRQEN, irqDat & wdg_pkg::IRQEN_MASK);
        i_host.wr(wdg_pkg::ADDR_TCTL, 8'h84);
        wait_pin(1, 1'b0, 5000);
        chk({7'h00, irq_or_test_out_n}, 8'h01, "no irq on reset");
        wait_pin(1, 1'b1, 5000);
        rd_exp(wdg_pkg::ADDR_TCTL, 8'h00);
        rd_exp(wdg_pkg::ADDR_IRQEN, 8'h00);
        rd_exp(wdg_pkg::ADDR_FLAGS, 8'h80);
        $display("test reset steering done");
        i_host.wr(wdg_pkg::ADDR_IRQEN, 8'h80);
        pulse_alarm();
        wait_pin(0, 1'b0, 5);
        rd_exp(wdg_pkg::ADDR_FLAGS, 8'h40);
        wait_pin(0, 1'b1, 5);
        i_host.wr(wdg_pkg::ADDR_IRQEN, 8'h00);
        pulse_alarm();
        count_hi(5, hi);
        chk(8'(hi), 8'h05, "masked alarm");
        rd_exp(wdg_pkg::ADDR_FLAGS, 8'h40);
        $display("test alarm done");
        freqTestIn = 1'b1;
        for (n = 0; n < 2; n++) begin
            i_host.wr(wdg_pkg::ADDR_TCTL, 8'h7c);
            i_host.wr(wdg_pkg::ADDR_IRQEN, 8'h80);
            @(negedge core_clk);
            power_fail_trip = 1'b1;
            batteryCheckLow = 1'b1;
            batteryCheckDone = 1'b1;
            wait_pin(1, 1'b0, 10);
            repeat (50) @(negedge core_clk);
            chk({6'h00, clockWriteHold, freqTestEnable}, 8'h00, "down");
            batteryCheckLow = (n == 0);
            power_fail_trip = 1'b0;
            wait_pin(1, 1'b1, 5000);
            batteryCheckDone = 1'b0;
            rd_exp(wdg_pkg::ADDR_FLAGS, n == 0 ? 8'h10 : 8'h00);
            rd_exp(wdg_pkg::ADDR_TCTL, 8'h00);
            rd_exp(wdg_pkg::ADDR_IRQEN, 8'h00);
        end
        freqTestIn = 1'b0;
        $display("test power cycle done");
        repeat (10) @(negedge core_clk);
        chk(8'(expQ.size()), 8'h00, "reads left");
        end_of_test();
    end
endmodule : wdg_irq_flag_logic_test
